// File: src/rom_seq_consts.svh
`ifndef ROM_SEQ_CONSTS_SVH
`define ROM_SEQ_CONSTS_SVH

// Clock of the controller.
`define CLK_PERIOD_NS      5
`define CLK_MHZ            200

// Memory geometry.
`define ADDR_W             17
`define DATA_W             8

// Command codes written into the device command register, and the erased byte value.
`define CMD_READ           8'h00
`define CMD_SETUP_ERASE    8'h20
`define CMD_SETUP_PROG     8'h40
`define CMD_ERASE_VERIFY   8'hA0
`define CMD_RESET          8'hFF
`define ERASED_BYTE        8'hFF

// Pulse limits and durations.
`define MAX_PROG_PULSES    25
`define MAX_ERASE_PULSES   30
`define PROG_PULSE_US      10
`define ERASE_PULSE_MS     100
`define PROG_PULSE_CYC     (`PROG_PULSE_US * `CLK_MHZ)
`define ERASE_PULSE_CYC    (`ERASE_PULSE_MS * 1000 * `CLK_MHZ)

// Pin cycle phases and supply settling, least times rounded up.
`define BUS_PHASE_NS       150
`define BUS_PHASE_CYC      ((`BUS_PHASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SUPPLY_SETTLE_NS   1000
`define SUPPLY_SETTLE_CYC  ((`SUPPLY_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: src/rom_seq_host.sv
`timescale 1ns/1ps
//Contract
// - Erase verify walks bytes from zero expecting all ones; re-erase on failure.
// - At most thirty erase pulses of 100 ms, three seconds total.
// - Erase verify may resume at the last failing address.
// - Program one byte at a time, at most 25 pulses of 10 us.
// - Verify after each program pulse; repeat until pass or limit.
// - After set-up program the first reset is data; write reset twice.
// - Always issue the reset command twice in succession.
// - Program is set-up code, address and data write, then verify read.
// - Program verify reads with select and gate low, strobe high, supply high.
// - Erase verify reads every byte the same way with supply at 12.5 V.
// - Identify: identify line high voltage, other address lines low, byte select.
// - Command 00H puts the device in read mode until changed.
// - Erase needs 20H twice; pulse runs from second strobe rise to next.
// - Command A0H with an address returns that byte for erase verify.
`include "rom_seq_consts.svh"

module rom_seq_host
    import rom_seq_pkg::*;
#(
    parameter int ADDR_W             = `ADDR_W,
    parameter int ERASE_PULSE_CYCLES = `ERASE_PULSE_CYC,
    parameter int MAX_PROG           = `MAX_PROG_PULSES,
    parameter int MAX_ERASE          = `MAX_ERASE_PULSES
) (
    input  wire logic               mclk,
    input  wire logic               rst_b,
    input  wire logic               cmdValid,
    output logic                    cmdReady,
    input  wire cmd_s               cmd,
    output logic                    rspValid,
    output rsp_s                    rsp,
    output logic [ADDR_W-1:0]       addressLines,
    output logic [`DATA_W-1:0]      dataLinesOut,
    output logic                    dataLinesOe,
    input  wire logic [`DATA_W-1:0] dataLinesIn,
    output logic                    chipSelect_b,
    output logic                    outGate_b,
    output logic                    writeStrobe_b,
    output logic                    programSupplyHighLevel,
    output logic                    idHighVoltageLine
);

    localparam int TIMER_W = $clog2(ERASE_PULSE_CYCLES + 1);

    // Refuse settings the counters and address path cannot serve.
    if (ADDR_W != `ADDR_W || ERASE_PULSE_CYCLES < `PROG_PULSE_CYC ||
        MAX_PROG < 1 || MAX_PROG > 31 || MAX_ERASE < 1 || MAX_ERASE > 31) begin : g_check
        $error("rom_seq_host: unsupported parameter values");
    end

    seq_e                stateReg;
    bus_e                busReg;
    cmd_s                cmdReg;
    logic [TIMER_W-1:0]  timerReg;
    logic [7:0]          phaseReg;
    logic [4:0]          pulseReg;
    logic [ADDR_W-1:0]   ptrReg;
    logic [`DATA_W-1:0]  rdByteReg;
    logic [`DATA_W-1:0]  dataSync;
    logic                busDoneReg;
    logic                busWriteReg;
    logic                busReq;
    logic                busWrite;
    logic [ADDR_W-1:0]   busAddr;
    logic [`DATA_W-1:0]  busData;
    logic                phaseEnd;

    // Read data comes from another device's pins, so it is resynchronised first.
    sync_two_flop #(.W(`DATA_W)) u_data_sync (
        .clk   (mclk),
        .rst_b (rst_b),
        .din   (dataLinesIn),
        .dout  (dataSync)
    );

    assign phaseEnd = (phaseReg == 8'(`BUS_PHASE_CYC - 1));

    // Each sequence state names the single pin cycle it needs.
    always_comb begin
        busReq   = 1'b1;
        busWrite = 1'b1;
        busAddr  = cmdReg.addr;
        busData  = `CMD_READ;
        case (stateReg)
            S_PSETUP:  busData = `CMD_SETUP_PROG;
            S_PDATA:   busData = cmdReg.data;
            S_PSTOP:   busData = `CMD_READ;
            S_PVERIFY: busWrite = 1'b0;
            S_ESETUP:  busData = `CMD_SETUP_ERASE;
            S_EGO:     busData = `CMD_SETUP_ERASE;
            S_EVCMD: begin
                busAddr = ptrReg;
                busData = `CMD_ERASE_VERIFY;
            end
            S_EVREAD: begin
                busAddr  = ptrReg;
                busWrite = 1'b0;
            end
            S_RST1:    busData = `CMD_RESET;
            S_RST2:    busData = `CMD_RESET;
            S_READ: begin
                busWrite = 1'b0;
                if (cmdReg.op == OP_IDENT) begin
                    busAddr = {{(ADDR_W-1){1'b0}}, cmdReg.addr[0]};
                end
            end
            default:   busReq = 1'b0;
        endcase
    end

    // Pin cycle engine: select, strobe, hold, each one phase long.
    // Data is driven only while the gate is high, so the two ends never fight.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            busReg        <= B_IDLE;
            phaseReg      <= 8'h00;
            busDoneReg    <= 1'b0;
            busWriteReg   <= 1'b0;
            rdByteReg     <= 8'h00;
            addressLines  <= '0;
            dataLinesOut  <= 8'h00;
            dataLinesOe   <= 1'b0;
            chipSelect_b  <= 1'b1;
            outGate_b     <= 1'b1;
            writeStrobe_b <= 1'b1;
        end else begin
            busDoneReg <= 1'b0;
            case (busReg)
                B_IDLE: begin
                    if (busReq && !busDoneReg) begin
                        busReg       <= B_SETUP;
                        phaseReg     <= 8'h00;
                        busWriteReg  <= busWrite;
                        addressLines <= busAddr;
                        dataLinesOut <= busData;
                        dataLinesOe  <= busWrite;
                        chipSelect_b <= 1'b0;
                    end
                end
                B_SETUP: begin
                    phaseReg <= phaseReg + 8'h01;
                    if (phaseEnd) begin
                        busReg   <= B_STROBE;
                        phaseReg <= 8'h00;
                        // Address is already stable when the strobe falls.
                        if (busWriteReg) begin
                            writeStrobe_b <= 1'b0;
                        end else begin
                            outGate_b <= 1'b0;
                        end
                    end
                end
                B_STROBE: begin
                    phaseReg <= phaseReg + 8'h01;
                    if (phaseEnd) begin
                        busReg        <= B_HOLD;
                        phaseReg      <= 8'h00;
                        writeStrobe_b <= 1'b1;
                        outGate_b     <= 1'b1;
                        if (!busWriteReg) begin
                            rdByteReg <= dataSync;
                        end
                    end
                end
                B_HOLD: begin
                    phaseReg <= phaseReg + 8'h01;
                    if (phaseEnd) begin
                        busReg       <= B_IDLE;
                        chipSelect_b <= 1'b1;
                        dataLinesOe  <= 1'b0;
                        busDoneReg   <= 1'b1;
                    end
                end
                default: busReg <= B_IDLE;
            endcase
        end
    end

    // Operation sequencer: supply control, pulse timing and verify loops.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            stateReg               <= S_IDLE;
            cmdReg                 <= '0;
            timerReg               <= '0;
            pulseReg               <= 5'h00;
            ptrReg                 <= '0;
            cmdReady               <= 1'b0;
            rspValid               <= 1'b0;
            rsp                    <= '0;
            programSupplyHighLevel <= 1'b0;
            idHighVoltageLine      <= 1'b0;
        end else begin
            rspValid <= 1'b0;
            case (stateReg)
                S_IDLE: begin
                    cmdReady <= 1'b1;
                    if (cmdValid && cmdReady) begin
                        cmdReady  <= 1'b0;
                        cmdReg    <= cmd;
                        pulseReg  <= 5'h00;
                        ptrReg    <= '0;
                        timerReg  <= TIMER_W'(`SUPPLY_SETTLE_CYC);
                        stateReg  <= S_RAMP;
                        // Plain reads run with the supply low so no write can land.
                        programSupplyHighLevel <= (cmd.op == OP_PROGRAM) ||
                                                  (cmd.op == OP_ERASE) ||
                                                  (cmd.op == OP_RESET);
                        idHighVoltageLine <= (cmd.op == OP_IDENT);
                    end
                end
                S_RAMP: begin
                    timerReg <= timerReg - 1'b1;
                    if (timerReg == '0) begin
                        case (cmdReg.op)
                            OP_PROGRAM: stateReg <= S_PSETUP;
                            OP_ERASE:   stateReg <= S_ESETUP;
                            OP_RESET:   stateReg <= S_RST1;
                            default:    stateReg <= S_READ;
                        endcase
                    end
                end
                S_PSETUP: if (busDoneReg) stateReg <= S_PDATA;
                S_PDATA: begin
                    if (busDoneReg) begin
                        stateReg <= S_PPULSE;
                        timerReg <= TIMER_W'(`PROG_PULSE_CYC - 1);
                        pulseReg <= pulseReg + 5'h01;
                    end
                end
                S_PPULSE: begin
                    timerReg <= timerReg - 1'b1;
                    if (timerReg == '0) stateReg <= S_PSTOP;
                end
                S_PSTOP: if (busDoneReg) stateReg <= S_PVERIFY;
                S_PVERIFY: begin
                    if (busDoneReg) begin
                        if (rdByteReg == cmdReg.data) begin
                            rsp.ok   <= 1'b1;
                            stateReg <= S_FINISH;
                        end else if (pulseReg == 5'(MAX_PROG)) begin
                            rsp.ok   <= 1'b0;
                            stateReg <= S_FINISH;
                        end else begin
                            stateReg <= S_PSETUP;
                        end
                        rsp.data <= rdByteReg;
                        timerReg <= TIMER_W'(`SUPPLY_SETTLE_CYC);
                    end
                end
                S_ESETUP: if (busDoneReg) stateReg <= S_EGO;
                S_EGO: begin
                    if (busDoneReg) begin
                        stateReg <= S_EPULSE;
                        timerReg <= TIMER_W'(ERASE_PULSE_CYCLES - 1);
                        pulseReg <= pulseReg + 5'h01;
                    end
                end
                S_EPULSE: begin
                    timerReg <= timerReg - 1'b1;
                    if (timerReg == '0) stateReg <= S_EVCMD;
                end
                S_EVCMD: if (busDoneReg) stateReg <= S_EVREAD;
                S_EVREAD: begin
                    if (busDoneReg) begin
                        rsp.data <= rdByteReg;
                        timerReg <= TIMER_W'(`SUPPLY_SETTLE_CYC);
                        if (rdByteReg == `ERASED_BYTE) begin
                            if (ptrReg == {ADDR_W{1'b1}}) begin
                                rsp.ok   <= 1'b1;
                                stateReg <= S_FINISH;
                            end else begin
                                ptrReg   <= ptrReg + 1'b1;
                                stateReg <= S_EVCMD;
                            end
                        end else if (pulseReg == 5'(MAX_ERASE)) begin
                            rsp.ok   <= 1'b0;
                            stateReg <= S_FINISH;
                        end else begin
                            // The failing address is kept, so verify resumes there.
                            stateReg <= S_ESETUP;
                        end
                    end
                end
                S_RST1: if (busDoneReg) stateReg <= S_RST2;
                S_RST2: begin
                    if (busDoneReg) begin
                        rsp.ok   <= 1'b1;
                        rsp.data <= `CMD_RESET;
                        timerReg <= TIMER_W'(`SUPPLY_SETTLE_CYC);
                        stateReg <= S_FINISH;
                    end
                end
                S_READ: begin
                    if (busDoneReg) begin
                        rsp.data <= rdByteReg;
                        rsp.ok   <= (cmdReg.op == OP_IDENT) ? ^rdByteReg : 1'b1;
                        timerReg <= TIMER_W'(`SUPPLY_SETTLE_CYC);
                        stateReg <= S_FINISH;
                    end
                end
                S_FINISH: begin
                    // Supplies drop first; the answer waits until they have settled.
                    programSupplyHighLevel <= 1'b0;
                    idHighVoltageLine      <= 1'b0;
                    rsp.pulses             <= pulseReg;
                    timerReg               <= timerReg - 1'b1;
                    if (timerReg == '0) begin
                        rspValid <= 1'b1;
                        stateReg <= S_IDLE;
                    end
                end
                default: stateReg <= S_IDLE;
            endcase
        end
    end

endmodule

// File: src/rom_seq_pkg.sv
`include "rom_seq_consts.svh"

package rom_seq_pkg;

    typedef enum logic [2:0] {
        OP_READ    = 3'h0,
        OP_PROGRAM = 3'h1,
        OP_ERASE   = 3'h2,
        OP_IDENT   = 3'h3,
        OP_RESET   = 3'h4
    } op_e;

    typedef struct packed {
        op_e                 op;
        logic [`ADDR_W-1:0]  addr;
        logic [`DATA_W-1:0]  data;
    } cmd_s;

    typedef struct packed {
        logic [`DATA_W-1:0]  data;
        logic                ok;
        logic [4:0]          pulses;
    } rsp_s;

    typedef enum logic [15:0] {
        S_IDLE    = 16'h0001,
        S_RAMP    = 16'h0002,
        S_PSETUP  = 16'h0004,
        S_PDATA   = 16'h0008,
        S_PPULSE  = 16'h0010,
        S_PSTOP   = 16'h0020,
        S_PVERIFY = 16'h0040,
        S_ESETUP  = 16'h0080,
        S_EGO     = 16'h0100,
        S_EPULSE  = 16'h0200,
        S_EVCMD   = 16'h0400,
        S_EVREAD  = 16'h0800,
        S_RST1    = 16'h1000,
        S_RST2    = 16'h2000,
        S_READ    = 16'h4000,
        S_FINISH  = 16'h8000
    } seq_e;

    typedef enum logic [3:0] {
        B_IDLE   = 4'h1,
        B_SETUP  = 4'h2,
        B_STROBE = 4'h4,
        B_HOLD   = 4'h8
    } bus_e;

endpackage

// File: src/sync_two_flop.sv
`timescale 1ns/1ps

module sync_two_flop #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    logic [W-1:0] stageReg;

    // The first stage feeds only the second; nothing else looks at it.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stageReg <= '0;
            dout     <= '0;
        end else begin
            stageReg <= din;
            dout     <= stageReg;
        end
    end

endmodule

// File: verif/rom_device_model.sv
`timescale 1ns/1ps
// Behavioural rewritable memory that answers the sequencer on its pins.
module rom_device_model #(
    parameter logic [7:0] MAKER_CODE  = 8'h8A, // Arbitrary value with odd parity.
    parameter logic [7:0] DEVICE_CODE = 8'h0E  // Arbitrary value with odd parity.
) (
    input  wire logic [16:0] addressLines,
    input  wire logic [7:0]  hostData,
    input  wire logic        hostOe,
    input  wire logic        chipSelect_b,
    input  wire logic        outGate_b,
    input  wire logic        writeStrobe_b,
    input  wire logic        programSupplyHighLevel,
    input  wire logic        idHighVoltageLine,
    input  wire logic        weakErase,
    output logic [7:0]       pinData
);
    localparam logic [2:0] RD = 3'h0, PSET = 3'h1, PROG = 3'h2, ESET = 3'h3, ERS = 3'h4,
                           EVF = 3'h5;
    logic [7:0]  mem [0:131071];
    logic [7:0]  floatPat;
    logic [16:0] latchAddr;
    logic [16:0] progAddr;
    logic [7:0]  progData;
    logic [2:0]  st;
    int          eraseCount;
    int          progPulses;
    logic        mainSupplyOk = 1'b0;
    realtime     pulseStart;
    realtime     lastPulseNs;
    logic [7:0]  writeLog [$];
    int          verifyLog [$];
    // Power-up lands in read mode, all cells erased, writes locked out until the supply is up.
    initial begin
        st = RD;
        floatPat = 8'h00;
        eraseCount = 0;
        progPulses = 0;
        for (int i = 0; i < 131072; i++) mem[i] = 8'hFF;
        #10 mainSupplyOk = 1'b1;
    end

    // No pull resistor, so a released bus shows a value that moves every cycle.
    always #5 floatPat = floatPat + 8'h35;

    // Data is driven only with select and gate low; weak erase fails addresses not yet reached.
    always @* begin
        if (hostOe) pinData = hostData;
        else if (chipSelect_b || outGate_b) pinData = floatPat;
        else if (idHighVoltageLine) pinData = addressLines[0] ? DEVICE_CODE : MAKER_CODE;
        else if (st == EVF && weakErase && addressLines >= eraseCount) pinData = 8'h00;
        else pinData = mem[addressLines];
    end
    // Dropping the program supply disables the command register.
    always @(negedge programSupplyHighLevel) st = RD;

    // The address is taken as the strobe falls.
    always @(negedge writeStrobe_b)
        if (!chipSelect_b && programSupplyHighLevel) latchAddr = addressLines;

    // Data is taken as the strobe rises; that edge also ends a running pulse.
    always @(posedge writeStrobe_b) begin
        if (!chipSelect_b && programSupplyHighLevel && mainSupplyOk) begin
            writeLog.push_back(hostData);
            if (st == PROG) begin
                lastPulseNs = $realtime - pulseStart;
                mem[progAddr] = mem[progAddr] & progData;
            end
            if (st == ERS) begin
                eraseCount++;
                for (int i = 0; i < 131072; i++) mem[i] = 8'hFF;
            end
            if (st == PSET) begin
                progAddr = latchAddr;
                progData = hostData;
                pulseStart = $realtime;
                progPulses++;
                st = PROG;
            end else begin
                case (hostData)
                    8'h20: st = (st == ESET) ? ERS : ESET;
                    8'h40: st = PSET;
                    8'hA0: begin
                        st = EVF;
                        verifyLog.push_back(int'(latchAddr));
                    end
                    default: st = RD;
                endcase
            end
        end
    end
endmodule

// File: verif/rom_seq_monitor.sv
`timescale 1ns/1ps
`include "rom_seq_consts.svh"
// Watches the command port and the pins of the sequencer.
module rom_seq_monitor
    import rom_seq_pkg::*;
#(
    parameter int ADDR_W   = 17,
    parameter int MAX_PROG = 25
) (
    input wire logic               mclk,
    input wire logic               rst_b,
    input wire logic               cmdValid,
    input wire logic               cmdReady,
    input wire cmd_s               cmd,
    input wire logic               rspValid,
    input wire rsp_s               rsp,
    input wire logic [ADDR_W-1:0]  addressLines,
    input wire logic [`DATA_W-1:0] dataLinesOut,
    input wire logic               dataLinesOe,
    input wire logic               chipSelect_b,
    input wire logic               outGate_b,
    input wire logic               writeStrobe_b,
    input wire logic               programSupplyHighLevel,
    input wire logic               idHighVoltageLine
);
    // One clock domain, so clock and reset are given once for all properties.
    default clocking mon_cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    a_strobe_selected: assert property (!writeStrobe_b |-> !chipSelect_b)
        else $error("Write strobe low while the chip is not selected.");
    a_write_supply_high: assert property (!writeStrobe_b |-> programSupplyHighLevel)
        else $error("Write strobe low while the program supply is low.");
    a_write_pins_steady: assert property (
        !writeStrobe_b && !$past(writeStrobe_b) |->
        $stable(addressLines) && $stable(dataLinesOut) && dataLinesOe)
        else $error("Address or data moved during a write strobe.");
    a_read_no_drive: assert property (
        !outGate_b |-> !dataLinesOe && writeStrobe_b && !chipSelect_b)
        else $error("Output gate low with data driven, strobe low or chip idle.");
    a_ident_addr_low: assert property (
        idHighVoltageLine && !chipSelect_b |-> addressLines[ADDR_W-1:1] == '0)
        else $error("Identify cycle with upper address lines not low.");
    a_rsp_one_cycle: assert property (rspValid |=> !rspValid && cmdReady)
        else $error("Answer pulse too long or ready not restored.");
    a_take_busy: assert property (cmdValid && cmdReady |=> !cmdReady [*8])
        else $error("Ready did not drop after a command was taken.");
    a_pulse_limit: assert property (rspValid |-> rsp.pulses <= MAX_PROG)
        else $error("Answer reports more pulses than allowed.");
    a_read_latency: assert property (
        cmdValid && cmdReady && cmd.op == OP_READ |-> ##[480:510] rspValid)
        else $error("Read answer missing in its fixed window.");

    c_prog_limit: cover property (rspValid && rsp.pulses == 5'h19);
    c_failed_op: cover property (rspValid && !rsp.ok);
    c_ident_read: cover property (idHighVoltageLine && !outGate_b);
endmodule

bind rom_seq_host rom_seq_monitor #(.ADDR_W(ADDR_W), .MAX_PROG(MAX_PROG)) u_mon (
    .mclk(mclk), .rst_b(rst_b), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmd(cmd),
    .rspValid(rspValid), .rsp(rsp), .addressLines(addressLines),
    .dataLinesOut(dataLinesOut), .dataLinesOe(dataLinesOe), .chipSelect_b(chipSelect_b),
    .outGate_b(outGate_b), .writeStrobe_b(writeStrobe_b),
    .programSupplyHighLevel(programSupplyHighLevel), .idHighVoltageLine(idHighVoltageLine)
);

// File: verif/tb_top.sv
`timescale 1ns/1ps
// Drives the sequencer against the memory model and judges every answer.
module tb_top
    import rom_seq_pkg::*;
;
    logic        mclk = 1'b0;
    logic        rst_b = 1'b0;
    logic        cmdValid = 1'b0;
    logic        cmdReady;
    cmd_s        cmd = '0;
    logic        rspValid;
    rsp_s        rsp;
    rsp_s        r;
    logic [16:0] addressLines;
    logic [7:0]  dataLinesOut;
    logic        dataLinesOe;
    logic [7:0]  pinData;
    logic        chipSelect_b;
    logic        outGate_b;
    logic        writeStrobe_b;
    logic        supply;
    logic        idLine;
    logic        weakErase = 1'b0;
    int          fails = 0;
    int          compares = 0;

    always #2.5 mclk = ~mclk;

    // Short erase pulse and a three-pulse erase limit keep the run small.
    rom_seq_host #(.ERASE_PULSE_CYCLES(2000), .MAX_ERASE(3)) DUT (
        .mclk(mclk), .rst_b(rst_b), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmd(cmd),
        .rspValid(rspValid), .rsp(rsp), .addressLines(addressLines),
        .dataLinesOut(dataLinesOut), .dataLinesOe(dataLinesOe), .dataLinesIn(pinData),
        .chipSelect_b(chipSelect_b), .outGate_b(outGate_b), .writeStrobe_b(writeStrobe_b),
        .programSupplyHighLevel(supply), .idHighVoltageLine(idLine)
    );

    rom_device_model u_dev (
        .addressLines(addressLines), .hostData(dataLinesOut), .hostOe(dataLinesOe),
        .chipSelect_b(chipSelect_b), .outGate_b(outGate_b), .writeStrobe_b(writeStrobe_b),
        .programSupplyHighLevel(supply), .idHighVoltageLine(idLine), .weakErase(weakErase),
        .pinData(pinData)
    );

    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Issues one command at a falling edge and waits, bounded, for its answer.
    task automatic run(input op_e op, input logic [16:0] addr, input logic [7:0] data);
        int n;
        cmd = '{op: op, addr: addr, data: data};
        cmdValid = 1'b1;
        n = 0;
        while (cmdReady !== 1'b1) begin
            @(negedge mclk);
            n++;
            if (n > 2000) begin
                fails++;
                give_verdict();
            end
        end
        @(negedge mclk);
        cmdValid = 1'b0;
        n = 0;
        while (rspValid !== 1'b1) begin
            @(negedge mclk);
            n++;
            if (n > 90000) begin
                fails++;
                give_verdict();
            end
        end
        r = rsp;
    endtask

    task automatic test_read(input logic [16:0] addr, input logic [7:0] exp);
        run(OP_READ, addr, 8'h00);
        check("readData", r.data, exp);
        check("readOk", r.ok, 1'b1);
    endtask

    task automatic test_program_once();
        int base;
        base = u_dev.writeLog.size();
        run(OP_PROGRAM, 17'h1FFFF, 8'h5A);
        check("progOk", r.ok, 1'b1);
        check("progPulses", r.pulses, 5'h01);
        check("setupCode", u_dev.writeLog[base], 8'h40);
        check("progByte", u_dev.writeLog[base+1], 8'h5A);
        check("pulseLong", u_dev.lastPulseNs >= 10000.0, 1'b1);
        check("pulseShort", u_dev.lastPulseNs < 12000.0, 1'b1);
        test_read(17'h1FFFF, 8'h5A);
    endtask

    // Setting a cleared bit back to one can never verify, so the pulse limit is reached.
    task automatic test_program_stuck();
        int base;
        base = u_dev.progPulses;
        run(OP_PROGRAM, 17'h1FFFF, 8'hA5);
        check("stuckOk", r.ok, 1'b0);
        check("stuckPulses", r.pulses, 5'h19);
        check("stuckSeen", u_dev.progPulses - base, 25);
        check("stuckData", r.data, 8'h00);
    endtask

    task automatic test_ident();
        for (int b = 0; b < 2; b++) begin
            run(OP_IDENT, 17'(b), 8'h00);
            check("identData", r.data, b ? 8'h0E : 8'h8A);
            check("identParity", r.ok, 1'b1);
        end
    endtask

    task automatic test_reset();
        int base;
        base = u_dev.writeLog.size();
        run(OP_RESET, 17'h00000, 8'h00);
        check("resetOk", r.ok, 1'b1);
        check("resetWrites", u_dev.writeLog.size() - base, 2);
        check("resetSecond", u_dev.writeLog[base+1], 8'hFF);
        check("resetMode", u_dev.st, 3'h0);
    endtask

    // A weak array fails one new address per pulse; verify must resume where it failed.
    task automatic test_erase();
        int base;
        int expAddr [6] = '{0, 1, 1, 2, 2, 3};
        base = u_dev.writeLog.size();
        u_dev.verifyLog.delete();
        weakErase = 1'b1;
        run(OP_ERASE, 17'h00000, 8'h00);
        check("eraseOk", r.ok, 1'b0);
        check("erasePulses", r.pulses, 5'h03);
        check("eraseSeen", u_dev.eraseCount, 3);
        check("eraseData", r.data, 8'h00);
        check("eraseFirst", u_dev.writeLog[base], 8'h20);
        check("eraseSecond", u_dev.writeLog[base+1], 8'h20);
        check("verifyCount", u_dev.verifyLog.size(), 6);
        for (int i = 0; i < 6; i++) check("verifyAddr", u_dev.verifyLog[i], expAddr[i]);
        weakErase = 1'b0;
        test_read(17'h1FFFF, 8'hFF);
    endtask

    // Reset for four cycles, then walk the scenarios.
    initial begin
        repeat (4) @(negedge mclk);
        rst_b = 1'b1;
        @(negedge mclk);
        test_read(17'h00123, 8'hFF);
        test_program_once();
        test_program_stuck();
        test_ident();
        test_reset();
        test_erase();
        give_verdict();
    end
endmodule
